// >>> boot_pkg.sv
package boot_pkg;

  // Boot mode strap encoding
  typedef enum logic [1:0] {
    boot_none = 2'h0,
    boot_host = 2'h1,
    boot_emem = 2'h2
  } boot_mode_t;

  // Power-down field values
  localparam logic [5:0] pd_none_code    = 6'h00;
  localparam logic [5:0] pd_pll_stop     = 6'h1a;
  localparam logic [5:0] pd_main_input_clock_stop   = 6'h1c;
  localparam int unsigned pd_width       = 6;

  // Pin synchronisers: hardware reset (inverted), test reset, emulator
  localparam int unsigned sync_pins      = 3;
  localparam logic [2:0]  pin_rst_level  = 3'h1;

  // Boot copy geometry
  localparam int unsigned rom_bytes      = 1024;
  localparam logic [31:0] rom_base       = 32'h9000_0000;
  localparam logic [31:0] boot_dest      = 32'h0000_0000;
  localparam logic [31:0] cpu_start_addr = 32'h0000_0000;

  // Register map, byte addresses
  localparam logic [7:0] reg_ctrl   = 8'h00;
  localparam logic [7:0] reg_status = 8'h04;
  localparam logic [7:0] reg_power  = 8'h08;

  // Control register bits
  localparam int unsigned ctrl_h2c_bit = 0;
  localparam int unsigned ctrl_clr_bit = 1;

  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Memory write issued by the boot copy
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_wr_t;

  // ROM byte read request and answer
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } rom_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rom_rsp_t;

endpackage

// >>> boot_reset_sequencer.sv
`timescale 1ns/10ps
// What this block does
// - Low reset holds all but the AXI slave, pin synchronisers and emulation latch in reset
// - Host boot stalls CPU, rest runs
// - Bus strap picks parallel port or PCI
// - Host interrupt bit ends stall, start 0
// - Stall interrupt not latched for CPU
// - Host may read and write memory
// - No new interrupt until CPU clears
// - DMA copies 1K ROM to zero
// - Pack bytes into 32-bit words
// - Block done releases CPU at zero
// - No boot runs from zero directly
// - Emulator masks user power-down modes
// - PLL/clock stop modes idle emulation
// - Boot needs only hardware reset released
// - ID variant valid after reset release
// - Test reset rise latches emulation pins
// - Stop mode codes exit only by reset
module boot_reset_sequencer
  import boot_pkg::*;
#(
  parameter bit big_endian = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        hw_reset_n,
  input  wire logic [1:0]  boot_mode_strap,
  input  wire logic        bus_select_strap,
  input  wire logic        test_reset_n,
  input  wire logic        emulation_config_pin0,
  input  wire logic        emulation_config_pin1,
  input  wire logic        emulator_attached,
  input  wire logic        emu_exec_cmd,
  input  wire logic        host_mem_access,
  output rom_req_t         rom_req,
  input  wire rom_rsp_t    rom_rsp,
  output mem_wr_t          mem_wr,
  output logic             cpu_stall,
  output logic             cpu_run,
  output logic [31:0]      cpu_start_pc,
  output logic             cpu_host_irq,
  output logic             host_port_sel,
  output logic             pci_sel,
  output logic             host_mem_grant,
  output logic             pd_gate_active,
  output logic             emu_spin_idle,
  output logic             id_variant_valid,
  output logic [1:0]       emu_config,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  localparam int unsigned word_count = rom_bytes / 4;

  typedef enum {st_reset, st_host_stall, st_copy_req, st_copy_wait, st_copy_write,
                st_running} boot_state_t;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Bit 0 carries the hardware reset inverted, so 1 means held
  logic [sync_pins-1:0] pin_raw;
  logic [sync_pins-1:0] pin_level;
  logic                 hw_rst_act;
  logic                 trst_level;
  logic                 trst_prev;
  logic                 emu_att;
  logic                 in_reset;

  assign pin_raw = {emulator_attached, test_reset_n, ~hw_reset_n};
  // Level changes only once stages two and three agree
  for (genvar p = 0; p < sync_pins; p++) begin : g_sync
    logic [2:0] stage;
    logic       level;
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        stage <= {3{pin_rst_level[p]}};
        level <= pin_rst_level[p];
      end else begin
        stage <= {stage[1:0], pin_raw[p]};
        if (stage[1] == stage[2]) begin
          level <= stage[2];
        end
      end
    end
    assign pin_level[p] = level;
  end
  assign hw_rst_act = pin_level[0];
  assign trst_level = pin_level[1];
  assign emu_att    = pin_level[2];
  assign in_reset   = reset | hw_rst_act;

  // ==========================================================
  // Strap capture
  // ==========================================================
  boot_mode_t mode;
  logic       bus_sel, straps_taken;

  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      straps_taken <= 1'b0;
      mode         <= boot_none;
      bus_sel      <= 1'b0;
    end else if (!straps_taken) begin
      straps_taken <= 1'b1;
      mode         <= boot_mode_t'(boot_mode_strap);
      bus_sel      <= bus_select_strap;
    end
  end

  // ==========================================================
  // Emulation configuration latch
  // ==========================================================
  // latch on rise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trst_prev  <= 1'b0;
      emu_config <= 2'h0;
    end else begin
      trst_prev <= trst_level;
      if (!hw_rst_act && trst_level && !trst_prev) begin
        emu_config <= {emulation_config_pin1, emulation_config_pin0};
      end
    end
  end

  assign id_variant_valid = ~hw_rst_act;

  // ==========================================================
  // Host interrupt bit and control registers
  // ==========================================================
  logic       h2c_bit, wr_fire, wr_ctrl, wr_power;
  logic       aw_held, w_held;
  logic [5:0] power_down_field;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  boot_state_t state;

  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl  = wr_fire && (aw_addr == reg_ctrl) && w_strb[0];
  assign wr_power = wr_fire && (aw_addr == reg_power) && w_strb[0];

  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      h2c_bit <= 1'b0;
    end else if (wr_ctrl && w_data[ctrl_h2c_bit]) begin
      h2c_bit <= 1'b1;
    end else if (wr_ctrl && w_data[ctrl_clr_bit] && state == st_running) begin
      h2c_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      cpu_host_irq <= 1'b0;
    end else if (wr_ctrl && w_data[ctrl_h2c_bit] && !h2c_bit && state == st_running) begin
      cpu_host_irq <= 1'b1;
    end else if (!h2c_bit) begin
      cpu_host_irq <= 1'b0;
    end
  end

  function automatic logic pd_stop_mode(input logic [5:0] f);
    return (f == pd_pll_stop) || (f == pd_main_input_clock_stop);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      power_down_field <= pd_none_code;
    end else if (wr_power && !pd_stop_mode(power_down_field)) begin
      power_down_field <= w_data[pd_width-1:0];
    end
  end
  assign pd_gate_active = (power_down_field != pd_none_code) && !emu_att;
  assign emu_spin_idle  = pd_stop_mode(power_down_field) && emu_exec_cmd;

  // ==========================================================
  // Boot sequencer
  // ==========================================================
  logic [7:0]  word_idx;
  logic [1:0]  byte_idx;
  logic [31:0] pack;

  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      state    <= st_reset;
      word_idx <= 8'h00;
      byte_idx <= 2'h0;
      pack     <= 32'h0;
    end else begin
      case (state)
        st_reset: begin
          if (straps_taken) begin
            case (mode)
              boot_host: state <= st_host_stall;
              boot_emem: state <= st_copy_req;
              default:   state <= st_running;
            endcase
          end
        end
        st_host_stall: begin
          if (h2c_bit) begin
            state <= st_running;
          end
        end
        st_copy_req: state <= st_copy_wait;
        st_copy_wait: begin
          if (rom_rsp.valid) begin
            if (big_endian) begin
              pack <= {pack[23:0], rom_rsp.data};
            end else begin
              pack <= {rom_rsp.data, pack[31:8]};
            end
            byte_idx <= byte_idx + 2'h1;
            state    <= (byte_idx == 2'h3) ? st_copy_write : st_copy_req;
          end
        end
        st_copy_write: begin
          word_idx <= word_idx + 8'h01;
          state    <= (word_idx == 8'(word_count - 1)) ? st_running : st_copy_req;
        end
        st_running: state <= st_running;
        default:    state <= st_reset;
      endcase
    end
  end

  assign rom_req.valid = (state == st_copy_req);
  assign rom_req.addr  = rom_base + {22'h0, word_idx, byte_idx};
  assign mem_wr.valid  = (state == st_copy_write);
  assign mem_wr.addr   = boot_dest + {22'h0, word_idx, 2'h0};
  assign mem_wr.data   = pack;

  assign cpu_run      = (state == st_running);
  assign cpu_stall    = ~cpu_run;
  assign cpu_start_pc = cpu_start_addr;
  assign host_port_sel = (mode == boot_host) && straps_taken && !bus_sel;
  assign pci_sel       = (mode == boot_host) && straps_taken && bus_sel;
  assign host_mem_grant = host_mem_access && !in_reset && (mode == boot_host);

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == reg_ctrl || aw_addr == reg_power) ? resp_okay : resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= resp_okay;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= resp_okay;
      case (s_axi_araddr[7:0])
        reg_ctrl:   s_axi_rdata <= {31'h0, h2c_bit};
        reg_status: s_axi_rdata <= {22'h0, emu_config, emu_att, pd_gate_active,
                                    bus_sel, mode, cpu_stall, hw_rst_act, cpu_run};
        reg_power:  s_axi_rdata <= {26'h0, power_down_field};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= resp_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> boot_seq_sva.sv
`timescale 1ns/10ps
module boot_seq_sva
  import boot_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        hw_reset_n,
  input wire logic        emulator_attached,
  input wire rom_req_t    rom_req,
  input wire mem_wr_t     mem_wr,
  input wire logic        cpu_stall,
  input wire logic        cpu_run,
  input wire logic [31:0] cpu_start_pc,
  input wire logic        cpu_host_irq,
  input wire logic        pd_gate_active,
  input wire logic        id_variant_valid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ====================
  // Steps
  sequence s_hw_held;
    !hw_reset_n [*7];
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ====================
  // Checks
  a_copy_stalls: assert property ((rom_req.valid || mem_wr.valid) |-> cpu_stall && !cpu_run)
    else $error("cpu not stalled during boot copy");
  a_start_pc_zero: assert property (cpu_start_pc == 32'h0)
    else $error("start address not zero");
  a_hw_hold: assert property (s_hw_held |-> cpu_stall && !mem_wr.valid && !rom_req.valid)
    else $error("activity under hardware reset");
  a_id_hidden: assert property (s_hw_held |-> !id_variant_valid)
    else $error("id variant valid in reset");
  a_emu_mask: assert property (emulator_attached [*5] |-> !pd_gate_active)
    else $error("power-down not masked");
  a_rom_req_pulse: assert property (rom_req.valid |=> !rom_req.valid)
    else $error("rom request longer than one cycle");
  a_rom_addr_span: assert property (rom_req.valid |-> (rom_req.addr - rom_base) < 32'h400)
    else $error("rom address outside image");
  a_stall_irq: assert property (cpu_stall |-> !cpu_host_irq)
    else $error("interrupt latched in stall");
  a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
endmodule

bind boot_reset_sequencer boot_seq_sva i_sva (.clk_sys, .reset, .hw_reset_n,
  .emulator_attached, .rom_req, .mem_wr, .cpu_stall, .cpu_run, .cpu_start_pc,
  .cpu_host_irq, .pd_gate_active, .id_variant_valid, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready);

// >>> rom_model.sv
`timescale 1ns/10ps
module rom_model
  import boot_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire rom_req_t rom_req,
  output rom_rsp_t      rom_rsp
);
  logic [7:0] byte_q;
  logic [2:0] delay;
  logic       busy;
  initial begin
    busy = 1'b0;
    delay = 3'h0;
    byte_q = 8'h00;
    rom_rsp = '0;
  end
  // ====================
  // Byte answers
  // Some words wait longer, so prompt and slow answers both occur
  // byte source
  always @(posedge clk_sys) begin
    rom_rsp.valid <= 1'b0;
    rom_rsp.data <= ~rom_rsp.data;
    if (rom_req.valid) begin
      busy <= 1'b1;
      byte_q <= rom_req.addr[7:0] + 8'h31;
      delay <= rom_req.addr[4] ? 3'h4 : 3'h0;
    end else if (busy && delay != 3'h0) begin
      delay <= delay - 3'h1;
    end else if (busy) begin
      busy <= 1'b0;
      rom_rsp <= '{1'b1, byte_q};
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top
  import boot_pkg::*;
;
  typedef struct packed {
    logic [1:0] mode;
    logic       bus;
    logic       stall;
  } row_t;
  logic clk_sys, reset, hw_reset_n, bus_select_strap, test_reset_n, emulator_attached;
  logic emulation_config_pin0, emulation_config_pin1, emu_exec_cmd, host_mem_access;
  logic cpu_stall, cpu_run, cpu_host_irq, host_port_sel, pci_sel, host_mem_grant;
  logic pd_gate_active, emu_spin_idle, id_variant_valid, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  boot_mode_strap, emu_config, s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] cpu_start_pc, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data;
  rom_req_t    rom_req;
  rom_rsp_t    rom_rsp;
  mem_wr_t     mem_wr;
  int          n_fail, samples_checked, cycles, n_words;
  row_t rows [5] = '{'{2'h0, 1'b0, 1'b0}, '{2'h3, 1'b1, 1'b0}, '{2'h1, 1'b0, 1'b1},
                     '{2'h1, 1'b1, 1'b1}, '{2'h2, 1'b0, 1'b1}};

  boot_reset_sequencer i_dut (
    .clk_sys, .reset, .hw_reset_n, .boot_mode_strap, .bus_select_strap, .test_reset_n,
    .emulation_config_pin0, .emulation_config_pin1, .emulator_attached, .emu_exec_cmd,
    .host_mem_access, .rom_req, .rom_rsp, .mem_wr, .cpu_stall, .cpu_run, .cpu_start_pc,
    .cpu_host_irq, .host_port_sel, .pci_sel, .host_mem_grant, .pd_gate_active,
    .emu_spin_idle, .id_variant_valid, .emu_config, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  rom_model i_rom (.clk_sys(clk_sys), .rom_req(rom_req), .rom_rsp(rom_rsp));

  // ====================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] ew(input int k);
    logic [7:0] b0;
    b0 = 8'(k * 4) + 8'h31;
    return {b0 + 8'h3, b0 + 8'h2, b0 + 8'h1, b0};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Straps flip after release to show they were captured
  task automatic hw_boot(input logic [1:0] m, input logic b);
    hw_reset_n <= 1'b0;
    boot_mode_strap <= m;
    bus_select_strap <= b;
    ticks(8);
    chk(id_variant_valid, 1'b0);
    n_words = 0;
    hw_reset_n <= 1'b1;
    ticks(8);
    bus_select_strap <= ~b;
    boot_mode_strap <= 2'h0;
    ticks(2);
    chk(id_variant_valid, 1'b1);
  endtask

  // ====================
  // Clock, timeout, copy monitor
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (mem_wr.valid) begin
      chk(mem_wr.addr, n_words * 4);
      chk(mem_wr.data, ew(n_words));
      n_words++;
    end
    if (cycles == 40000) begin
      n_fail++;
      wrap_up;
    end
  end

  // ====================
  // Sequence
  initial begin
    {reset, hw_reset_n, test_reset_n, emulator_attached, emu_exec_cmd} = 5'h10;
    {emulation_config_pin0, emulation_config_pin1, bus_select_strap} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {boot_mode_strap, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    host_mem_access = 1'b1;
    s_axi_wstrb = 4'hf;
    ticks(4);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      hw_boot(rows[i].mode, rows[i].bus);
      chk(cpu_stall, rows[i].stall);
      if (rows[i].mode == boot_host) begin
        chk({host_port_sel, pci_sel, host_mem_grant}, {~rows[i].bus, rows[i].bus, 1'b1});
        axw(reg_ctrl, 32'h1);
      end else begin
        chk({host_port_sel, pci_sel, host_mem_grant}, 3'h0);
      end
      for (int k = 0; k < 8000 && !cpu_run; k++) @(posedge clk_sys);
      chk(cpu_run, 1'b1);
      chk(cpu_host_irq, 1'b0);
      chk(cpu_start_pc, 32'h0);
      if (rows[i].mode == boot_emem) chk(n_words, 256);
    end
    axr(8'h40);
    chk(rd_resp, resp_slverr);
    chk(rd_data, 32'h0);
    axw(8'h40, 32'h1);
    chk(wr_resp, resp_slverr);
    axw(reg_ctrl, 32'h1);
    chk(cpu_host_irq, 1'b1);
    axw(reg_ctrl, 32'h2);
    axr(reg_ctrl);
    chk({cpu_host_irq, rd_data[0]}, 2'h0);
    axw(reg_ctrl, 32'h1);
    chk({cpu_host_irq, wr_resp}, {1'b1, resp_okay});
    emulator_attached <= 1'b1;
    axw(reg_power, {26'h0, pd_pll_stop});
    ticks(6);
    chk(pd_gate_active, 1'b0);
    emulator_attached <= 1'b0;
    emu_exec_cmd <= 1'b1;
    ticks(6);
    chk({pd_gate_active, emu_spin_idle}, 2'h3);
    axw(reg_power, {26'h0, pd_main_input_clock_stop});
    axr(reg_power);
    chk(rd_data[5:0], pd_pll_stop);
    emulation_config_pin1 <= 1'b1;
    ticks(4);
    test_reset_n <= 1'b1;
    ticks(6);
    {emulation_config_pin1, emulation_config_pin0} <= 2'h1;
    ticks(4);
    chk(emu_config, 2'h2);
    reset <= 1'b1;
    ticks(2);
    reset <= 1'b0;
    ticks(2);
    axr(reg_power);
    chk(rd_data[5:0], pd_none_code);
    axw(reg_power, {26'h0, pd_main_input_clock_stop});
    ticks(4);
    chk(emu_spin_idle, 1'b1);
    wrap_up;
  end
endmodule
